// ### ccp_map.svh
// register offsets, field positions, reset values and timing counts of the capture unit
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

`define CCP_NUM_CH 5
`define CCP_INSTR_DIV 4

// word-aligned byte offsets
`define CCP_CTL_BASE 8'h00
`define CCP_CAP_LO_BASE 8'h20
`define CCP_CAP_HI_BASE 8'h40
`define CCP_FLAG_OFS 8'h60
`define CCP_TMR_CTL_OFS 8'h64
`define CCP_TMR_LO_OFS 8'h68
`define CCP_TMR_HI_OFS 8'h6C
`define CCP_DIR_OFS 8'h70
`define CCP_LATCH_OFS 8'h74

// field positions
`define CCP_MODE_LSB 0
`define CCP_MODE_MSB 3
`define CCP_TMR_ON_BIT 0
`define CCP_TMR_EXT_BIT 1

// reset values
`define CCP_CTL_RST 8'h00
`define CCP_TMR_CTL_RST 2'h0
`define CCP_TMR_RST 16'h0000
`define CCP_DIR_RST 5'h1F
`define CCP_LATCH_RST 5'h00

`endif

// ### ccp_pkg.sv
// types shared by the capture unit
package ccp_pkg;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_FALL = 4'b0100,
    MODE_RISE = 4'b0101,
    MODE_RISE4 = 4'b0110,
    MODE_RISE16 = 4'b0111
  } capture_mode_t;

  typedef logic [15:0] count_t;

endpackage

// ### capture_channel.sv
// one capture channel: pin synchroniser, edge prescaler and capture value
`timescale 1ns/10ps
module capture_channel (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] mode_i,
  input wire logic pin_i,
  input wire logic pin_is_input_i,
  input wire logic latch_i,
  input wire ccp_pkg::count_t timer_i,
  output logic event_o,
  output ccp_pkg::count_t value_o
);
  import ccp_pkg::*;

  logic sync1_r, sync2_r, sync3_r;
  logic pin_lvl_r, pin_lvl_nxt;
  logic in_prev_r;
  logic [3:0] pre_cnt_r, pre_cnt_nxt;
  count_t value_r, value_nxt;
  logic event_r;

  // pin level counts once the second and third stages agree
  wire pin_settled = (sync2_r == sync3_r);
  wire in_lvl = pin_is_input_i ? pin_lvl_r : latch_i;
  wire rise = in_lvl & ~in_prev_r;
  wire fall = ~in_lvl & in_prev_r;
  wire is_capture = (mode_i == MODE_FALL) || (mode_i == MODE_RISE) ||
                    (mode_i == MODE_RISE4) || (mode_i == MODE_RISE16);
  wire hit_fall = (mode_i == MODE_FALL) & fall;
  wire hit_rise = (mode_i == MODE_RISE) & rise;
  wire hit_rise4 = (mode_i == MODE_RISE4) & rise & (pre_cnt_r[1:0] == 2'h3);
  wire hit_rise16 = (mode_i == MODE_RISE16) & rise & (pre_cnt_r == 4'hF);
  wire hit = hit_fall | hit_rise | hit_rise4 | hit_rise16;

  assign pin_lvl_nxt = pin_settled ? sync3_r : pin_lvl_r;
  // counter runs on in any capture mode, so a prescaler switch keeps its count
  assign pre_cnt_nxt = !is_capture ? 4'h0 : (rise ? pre_cnt_r + 4'h1 : pre_cnt_r);
  assign value_nxt = hit ? timer_i : value_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      pin_lvl_r <= 1'b0;
      in_prev_r <= 1'b0;
      pre_cnt_r <= 4'h0;
      value_r <= 16'h0000;
      event_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_lvl_r <= pin_lvl_nxt;
      in_prev_r <= in_lvl;
      pre_cnt_r <= pre_cnt_nxt;
      value_r <= value_nxt;
      event_r <= hit;
    end
  end

  assign event_o = event_r;
  assign value_o = value_r;

endmodule // capture_channel

// ### ccp_input_capture_unit.sv
// five-channel input capture unit with shared 16-bit timer and wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "ccp_map.svh"

// Summary of operation
// - five channels, all with the same capture behaviour.
// - a qualifying pin event copies the whole 16-bit shared timer at once.
// - mode picks falling, rising, every 4th rising or every 16th rising edge.
// - each capture sets that channel's interrupt flag.
// - flag stays set until software clears it; software must clear it.
// - a new capture overwrites an unread value, with no overrun indication.
// - with pin as output, a port latch write changing level acts as event.
// - a mode change may cause a spurious capture; it is not suppressed.
// - prescaler held cleared when the channel is off or not capturing.
// - every reset clears the prescaler counter.
// - switching between prescaler settings keeps the count; may give a spurious capture.
// - on instruction clock the timer halts in sleep and resumes afterwards.
// - with an external timer clock capture keeps working during sleep.
module ccp_input_capture_unit (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire logic ext_clk_i,
  input wire logic [4:0] ccp_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import ccp_pkg::*;

  // address falls in a five-word block starting at base
  function automatic logic slot_hit(input logic [7:0] adr, input logic [7:0] base);
    slot_hit = (adr[7:5] == base[7:5]) && (adr[4:2] < 3'd5) && (adr[1:0] == 2'b00);
  endfunction

  logic ack_r;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic [7:0] ctl_r [0:4];
  logic [4:0] flag_r, flag_nxt;
  logic [1:0] tmr_ctl_r;
  count_t timer_r, timer_nxt;
  logic [4:0] dir_r;
  logic [4:0] latch_r;
  logic [1:0] div_r;
  logic instr_en_r;
  logic ext1_r, ext2_r, ext3_r;
  logic ext_lvl_r;
  logic [4:0] cap_evt;
  count_t cap_val [0:4];

  // bus request handling: write lands on the edge that sees ack high
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_fire = req & wb_we_i & ack_r;
  wire [2:0] slot = wb_adr_i[4:2];
  wire hit_ctl = slot_hit(wb_adr_i, `CCP_CTL_BASE);
  wire hit_cap_lo = slot_hit(wb_adr_i, `CCP_CAP_LO_BASE);
  wire hit_cap_hi = slot_hit(wb_adr_i, `CCP_CAP_HI_BASE);
  wire hit_flag = (wb_adr_i == `CCP_FLAG_OFS);
  wire hit_tmr_ctl = (wb_adr_i == `CCP_TMR_CTL_OFS);
  wire hit_tmr_lo = (wb_adr_i == `CCP_TMR_LO_OFS);
  wire hit_tmr_hi = (wb_adr_i == `CCP_TMR_HI_OFS);
  wire hit_dir = (wb_adr_i == `CCP_DIR_OFS);
  wire hit_latch = (wb_adr_i == `CCP_LATCH_OFS);
  wire wr_lo = wr_fire & wb_sel_i[0];

  // external timer clock: three stages, edge counted once two and three agree
  wire ext_settled = (ext2_r == ext3_r);
  wire ext_rise = ext_settled & ext3_r & ~ext_lvl_r;

  // timer tick: instruction clock stops in sleep, external clock keeps running
  wire tmr_on = tmr_ctl_r[`CCP_TMR_ON_BIT];
  wire tmr_ext = tmr_ctl_r[`CCP_TMR_EXT_BIT];
  wire tmr_tick = tmr_on & (tmr_ext ? ext_rise : (instr_en_r & ~sleep_i));

  // software preload of a timer byte wins over a tick in the same cycle
  always_comb begin
    timer_nxt = tmr_tick ? timer_r + 16'h0001 : timer_r;
    if (wr_lo && hit_tmr_lo) begin
      timer_nxt[7:0] = wb_dat_i[7:0];
    end else if (wr_lo && hit_tmr_hi) begin
      timer_nxt[15:8] = wb_dat_i[7:0];
    end
  end

  // flags: write one to clear, a capture in the same cycle wins
  wire [4:0] flag_clr = (wr_lo && hit_flag) ? wb_dat_i[4:0] : 5'h00;
  assign flag_nxt = (flag_r & ~flag_clr) | cap_evt;

  // read data, loaded on the request edge
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_ctl) begin
      rd_nxt[7:0] = ctl_r[slot];
    end else if (hit_cap_lo) begin
      rd_nxt[7:0] = cap_val[slot][7:0];
    end else if (hit_cap_hi) begin
      rd_nxt[7:0] = cap_val[slot][15:8];
    end else if (hit_flag) begin
      rd_nxt[4:0] = flag_r;
    end else if (hit_tmr_ctl) begin
      rd_nxt[1:0] = tmr_ctl_r;
    end else if (hit_tmr_lo) begin
      rd_nxt[7:0] = timer_r[7:0];
    end else if (hit_tmr_hi) begin
      rd_nxt[7:0] = timer_r[15:8];
    end else if (hit_dir) begin
      rd_nxt[4:0] = dir_r;
    end else if (hit_latch) begin
      rd_nxt[4:0] = latch_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rd_r <= rd_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flag_r <= 5'h00;
      tmr_ctl_r <= `CCP_TMR_CTL_RST;
      timer_r <= `CCP_TMR_RST;
      dir_r <= `CCP_DIR_RST;
      latch_r <= `CCP_LATCH_RST;
    end else begin
      flag_r <= flag_nxt;
      timer_r <= timer_nxt;
      if (wr_lo && hit_tmr_ctl) begin
        tmr_ctl_r <= wb_dat_i[1:0];
      end
      if (wr_lo && hit_dir) begin
        dir_r <= wb_dat_i[4:0];
      end
      if (wr_lo && hit_latch) begin
        latch_r <= wb_dat_i[4:0];
      end
    end
  end

  // instruction clock enable: one pulse every four system clocks
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      instr_en_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      instr_en_r <= (div_r == 2'(`CCP_INSTR_DIV - 1));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext1_r <= 1'b0;
      ext2_r <= 1'b0;
      ext3_r <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext1_r <= ext_clk_i;
      ext2_r <= ext1_r;
      ext3_r <= ext2_r;
      if (ext_settled) begin
        ext_lvl_r <= ext3_r;
      end
    end
  end

  // five identical channels sharing one timer
  genvar ch;
  generate
    for (ch = 0; ch < `CCP_NUM_CH; ch = ch + 1) begin : g_ch
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          ctl_r[ch] <= `CCP_CTL_RST;
        end else if (wr_lo && hit_ctl && (slot == 3'(ch))) begin
          ctl_r[ch] <= wb_dat_i[7:0];
        end
      end

      capture_channel u_chan (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .mode_i(ctl_r[ch][`CCP_MODE_MSB:`CCP_MODE_LSB]),
        .pin_i(ccp_pin_i[ch]),
        .pin_is_input_i(dir_r[ch]),
        .latch_i(latch_r[ch]),
        .timer_i(timer_r),
        .event_o(cap_evt[ch]),
        .value_o(cap_val[ch])
      );
    end
  endgenerate

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

endmodule // ccp_input_capture_unit

// ### ccp_input_capture_unit_assertions.sv
// bus port assertions of the capture unit, with its bind
`timescale 1ns/10ps
module ccp_input_capture_unit_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire logic ext_clk_i,
  input wire logic [4:0] ccp_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd = take & ~wb_we_i;
  wire spare = (wb_adr_i >= 8'h78) | (wb_adr_i inside {8'h14, 8'h18, 8'h1C});
  wire byte_reg = (wb_adr_i < 8'h60) | (wb_adr_i inside {8'h68, 8'h6C});
  a_ack_follows: assert property (take |=> wb_ack_o) else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  a_dat_hold: assert property (!take |=> $stable(wb_dat_o)) else $error("read data moved");
  a_flag_width: assert property (rd && wb_adr_i == 8'h60 |=> wb_dat_o[31:5] == 0) else $error("flag bits");
  a_byte_regs: assert property (rd && byte_reg |=> wb_dat_o[31:8] == 0) else $error("byte register width");
  a_unmapped_zero: assert property (rd && spare |=> wb_dat_o == 0) else $error("unmapped not zero");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 0)
    else $error("bus active in reset");
endmodule // ccp_input_capture_unit_checker
bind ccp_input_capture_unit ccp_input_capture_unit_checker checker_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .sleep_i(sleep_i), .ext_clk_i(ext_clk_i), .ccp_pin_i(ccp_pin_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o));

// ### capture_pin_source.sv
// model of the external event sources on the capture pins
`timescale 1ns/10ps
module capture_pin_source (
  input wire logic clk_sys_i,
  output logic [4:0] pin_o
);
  initial pin_o = 5'h00;
  // each level held 9 clocks, well above the shortest accepted pulse
  task automatic drive(input int ch, input logic v);
    @(posedge clk_sys_i);
    pin_o[ch] <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      drive(ch, 1'b1);
      drive(ch, 1'b0);
    end
  endtask
endmodule // capture_pin_source

// ### ccp_input_capture_unit_tb_top.sv
// self-checking bench of the capture unit
`timescale 1ns/10ps
module ccp_input_capture_unit_tb_top;
  import ccp_pkg::*;
  logic clk_sys_i, rst_i, sleep, ext_clk, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rv;
  logic [4:0] pin;
  int n_errors, checked, cycles;
  ccp_input_capture_unit dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sleep_i(sleep), .ext_clk_i(ext_clk),
    .ccp_pin_i(pin), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  capture_pin_source src (.clk_sys_i(clk_sys_i), .pin_o(pin));
  initial begin
    clk_sys_i = 0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'h1;
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(rv, e);
  endtask
  task automatic set_mode(input int ch, input capture_mode_t m);
    wr(8'(ch * 4), 32'h0);
    wr(8'(ch * 4), 32'(m));
    wr(8'h60, 32'h1F);
  endtask
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i) ext_clk <= 1;
      repeat (4) @(posedge clk_sys_i);
      ext_clk <= 0;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    rst_i = 1; sleep = 0; ext_clk = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 0;
    rd(8'h00, 32'h0);
    rd(8'h70, 32'h1F);
    rd(8'h80, 32'h0);
    for (int n = 0; n < 5; n++) begin
      wr(8'h68, 32'(n));
      wr(8'h6C, 32'h12);
      set_mode(n, MODE_RISE);
      src.pulses(n, 1);
      rd(8'h60, 32'(1 << n));
      rd(8'(8'h20 + n * 4), 32'(n));
      rd(8'(8'h40 + n * 4), 32'h12);
      wr(8'h68, 32'hA5);
      src.pulses(n, 1);
      rd(8'(8'h20 + n * 4), 32'hA5);
      rd(8'h60, 32'(1 << n));
      wr(8'h60, 32'(1 << n));
      rd(8'h60, 32'h0);
    end
    set_mode(0, MODE_RISE4);
    src.pulses(0, 3);
    rd(8'h60, 32'h0);
    src.pulses(0, 1);
    rd(8'h60, 32'h1);
    set_mode(0, MODE_RISE16);
    src.pulses(0, 15);
    rd(8'h60, 32'h0);
    src.pulses(0, 1);
    rd(8'h60, 32'h1);
    set_mode(0, MODE_RISE16);
    src.pulses(0, 2);
    wr(8'h00, 32'(MODE_RISE4));
    wr(8'h60, 32'h1F);
    src.pulses(0, 2);
    rd(8'h60, 32'h1);
    src.drive(0, 1'b1);
    set_mode(0, MODE_FALL);
    src.drive(0, 1'b0);
    rd(8'h60, 32'h1);
    set_mode(0, MODE_RISE);
    wr(8'h70, 32'h1E);
    wr(8'h74, 32'h1);
    repeat (4) @(posedge clk_sys_i);
    rd(8'h60, 32'h1);
    wr(8'h68, 32'h0);
    wr(8'h6C, 32'h0);
    sleep <= 1;
    wr(8'h64, 32'h1);
    repeat (20) @(posedge clk_sys_i);
    rd(8'h68, 32'h0);
    wr(8'h64, 32'h3);
    ext_ticks(5);
    rd(8'h68, 32'h5);
    wr(8'h70, 32'h1F);
    wr(8'h64, 32'h0);
    wr(8'h60, 32'h1F);
    src.pulses(0, 1);
    rd(8'h20, 32'h5);
    rd(8'h60, 32'h1);
    print_verdict();
  end
endmodule // ccp_input_capture_unit_tb_top
